// ===== design/smseq_pkg.sv
// smseq_pkg: constants and carriers for the scalar microcode sequencer.
// assumes a single 50 MHz clock domain; no bus, loads arrive on a plain port.
package smseq_pkg;
    localparam int ADDR_W      = 8;
    localparam int DEPTH       = 256;
    localparam int SCAL_W      = 120;
    localparam int ASSOC_W     = 96;
    localparam int FP_W        = 48;
    localparam int SCAL_PAR    = 5;
    localparam int ASSOC_PAR   = 4;
    localparam int FP_PAR      = 2;
    localparam int CLK_NS      = 20;
    localparam int CYCLE_NS    = 20;
    localparam int CYCLE_CLKS  = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
    // scalar word fields (data bits 0..114, parity 115..119)
    localparam int NEXT_LSB    = 0;
    localparam int SEQ_LSB     = 8;
    localparam int FPSTART_LSB = 10;
    localparam int FPREQ_BIT   = 18;
    localparam int DIVREQ_BIT  = 19;
    localparam int VARLEN_BIT  = 20;
    localparam int MULTI_BIT   = 21;
    localparam int LAST_BIT    = 22;
    localparam int SCAL_DATA   = 115;
    // assoc word fields (data bits 0..91, parity 92..95)
    localparam int JUMP_LSB    = 0;
    localparam int ASEL_LSB    = 8;
    localparam int ADONE_BIT   = 10;
    localparam int ASSOC_DATA  = 92;
    // divide word fields (data 0..45, parity 46..47)
    localparam int LINK_LSB    = 0;
    localparam int FP_DATA     = 46;
    localparam logic [7:0] IDLE_ADDR  = 8'h00;
    localparam logic [7:0] ASSOC_IDLE = 8'h00;
    // continuation next-address select
    localparam logic [1:0] SEQ_INC  = 2'h0;
    localparam logic [1:0] SEQ_JUMP = 2'h1;
    localparam logic [1:0] SEQ_SENS = 2'h2;
    // assoc next-address select
    localparam logic [1:0] ASEL_START = 2'h0;
    localparam logic [1:0] ASEL_JUMP  = 2'h1;
    localparam logic [1:0] ASEL_STM   = 2'h2;
    // load target memory codes
    localparam logic [2:0] MEM_DISP = 3'h0;
    localparam logic [2:0] MEM_CONT = 3'h1;
    localparam logic [2:0] MEM_ASSC = 3'h2;
    localparam logic [2:0] MEM_FP   = 3'h3;
    localparam logic [2:0] MEM_DIV  = 3'h4;

    typedef enum logic {SMSEQ_DISP, SMSEQ_CONT} smseq_src_e;

    typedef struct packed {
        logic                 wrStrobe;
        logic [2:0]           memSel;
        logic [ADDR_W-1:0]    addr;
        logic [SCAL_W-1:0]    data;
    } smseq_load_s;

    typedef struct packed {
        logic       scalar;
        logic       assoc;
        logic       fp;
        logic       divide;
    } smseq_fault_s;
endpackage : smseq_pkg

// ===== design/smseq_sequencer.sv
// smseq_sequencer: five microcode stores with their address sequencing.
// assumes instruction stack, issue unit, end-of-operation and sense inputs
// come from logic on clk; the maintenance side drives the load channel on clk too.
`timescale 1ns/10ps
`default_nettype none

module smseq_sequencer
    import smseq_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  loadMode,
    input  wire smseq_load_s           loadBus,
    input  wire logic                  instrReady,
    input  wire logic [ADDR_W-1:0]     funcCode,
    input  wire logic                  issueReady,
    input  wire logic                  endOfOp,
    input  wire logic [3:0]            senseIndex,
    input  wire logic                  assocStart,
    input  wire logic [ADDR_W-1:0]     assocStartAddr,
    input  wire logic [ADDR_W-1:0]     tableModeAddr,
    output logic                       instrTaken,
    output logic                       fromContinuation,
    output logic [SCAL_W-1:0]          scalarWord,
    output logic [ASSOC_W-1:0]         assocWord,
    output logic                       assocBusy,
    output logic [FP_W-1:0]            fpWord,
    output logic                       fpValid,
    output logic [FP_W-1:0]            divideWord,
    output logic                       divideBusy,
    output smseq_fault_s               parityFault
);
    logic [SCAL_W-1:0]  dispatchRom     [DEPTH];
    logic [SCAL_W-1:0]  continuationRom [DEPTH];
    logic [ASSOC_W-1:0] assocRom        [DEPTH];
    logic [FP_W-1:0]    fpRom           [DEPTH];
    logic [FP_W-1:0]    divideRom       [DEPTH];

    smseq_src_e        src_reg;
    logic [ADDR_W-1:0] contAddr_reg;
    logic [ADDR_W-1:0] contAddr_next;
    logic [ADDR_W-1:0] assocAddr_reg;
    logic [ADDR_W-1:0] assocAddr_next;
    logic [ADDR_W-1:0] divAddr_reg;
    logic [ADDR_W-1:0] divAddr_next;
    logic              contWait_reg;
    logic              scalValid_reg;
    logic              assocValid_reg;
    logic              divValid_reg;
    logic              fpChk_reg;
    logic              dispFire;
    logic              contDone;
    logic              running;

    // writes reach the stores only in load mode; one address serves all
    // stores have no reset: contents are valid only after a load
    always_ff @(posedge clk) begin
        if (loadMode && loadBus.wrStrobe) begin
            unique case (loadBus.memSel)
                MEM_DISP: dispatchRom[loadBus.addr]     <= loadBus.data;
                MEM_CONT: continuationRom[loadBus.addr] <= loadBus.data;
                MEM_ASSC: assocRom[loadBus.addr]        <= loadBus.data[ASSOC_W-1:0];
                MEM_FP:   fpRom[loadBus.addr]           <= loadBus.data[FP_W-1:0];
                MEM_DIV:  divideRom[loadBus.addr]       <= loadBus.data[FP_W-1:0];
                default: ;
            endcase
        end
    end

    assign running = !loadMode;

    // dispatch fires when an instruction is ready and issue can accept it
    // a pending multicycle entry holds off dispatch so continuation runs first
    assign dispFire   = running && src_reg == SMSEQ_DISP && instrReady && issueReady
                        && !(scalValid_reg && scalarWord[MULTI_BIT]);
    assign instrTaken = dispFire;
    // a continuation run ends on its last step, or after end-of-op if variable
    assign contDone = src_reg == SMSEQ_CONT &&
        (contWait_reg ? endOfOp
                      : (scalarWord[LAST_BIT] && !scalarWord[VARLEN_BIT]) ||
                        (scalarWord[LAST_BIT] && scalarWord[VARLEN_BIT] && endOfOp));

    // dispatch/continuation selection
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            src_reg      <= SMSEQ_DISP;
            contWait_reg <= 1'b0;
        end else if (loadMode) begin
            src_reg      <= SMSEQ_DISP;
            contWait_reg <= 1'b0;
        end else if (src_reg == SMSEQ_DISP) begin
            if (scalValid_reg && scalarWord[MULTI_BIT])
                src_reg <= SMSEQ_CONT;
            else
                src_reg <= SMSEQ_DISP;
        end else if (contDone) begin
            src_reg      <= SMSEQ_DISP;
            contWait_reg <= 1'b0;
        end else if (scalarWord[LAST_BIT] && scalarWord[VARLEN_BIT]) begin
            contWait_reg <= 1'b1;
        end
    end

    // continuation next address from its own word, entry from dispatch jump
    always_comb begin
        contAddr_next = contAddr_reg;
        if (loadMode)
            contAddr_next = loadBus.addr;
        else if (src_reg == SMSEQ_DISP)
            contAddr_next = scalarWord[NEXT_LSB +: ADDR_W];
        else if (!contWait_reg) begin
            unique case (scalarWord[SEQ_LSB +: 2])
                SEQ_INC:  contAddr_next = contAddr_reg + 8'h01;
                SEQ_JUMP: contAddr_next = scalarWord[NEXT_LSB +: ADDR_W];
                SEQ_SENS: contAddr_next = {scalarWord[NEXT_LSB+4 +: 4], senseIndex};
                default:  contAddr_next = contAddr_reg + 8'h01;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            contAddr_reg <= 8'h00;
        else
            contAddr_reg <= contAddr_next;
    end

    // scalar word: dispatch addressed only by the function code
    // no fetch follows a last word; a variable one is held until end-of-op
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scalarWord    <= '0;
            scalValid_reg <= 1'b0;
        end else if (dispFire) begin
            scalarWord    <= dispatchRom[funcCode];
            scalValid_reg <= 1'b1;
        end else if (running && src_reg == SMSEQ_CONT && !contWait_reg
                     && !scalarWord[LAST_BIT]) begin
            scalarWord    <= continuationRom[contAddr_next];
            scalValid_reg <= 1'b1;
        end else if (running && src_reg == SMSEQ_DISP && scalValid_reg
                     && scalarWord[MULTI_BIT]) begin
            scalarWord    <= continuationRom[contAddr_next];
            scalValid_reg <= 1'b1;
        end else begin
            scalValid_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            fromContinuation <= 1'b0;
        else
            fromContinuation <= src_reg == SMSEQ_CONT || (src_reg == SMSEQ_DISP
                                && scalValid_reg && scalarWord[MULTI_BIT] && running);
    end

    // associative sequencing: idle loop at zero until a start arrives
    always_comb begin
        assocAddr_next = assocAddr_reg;
        if (loadMode)
            assocAddr_next = ASSOC_IDLE;
        else if (!assocBusy) begin
            if (assocStart)
                assocAddr_next = assocStartAddr;
        end else begin
            unique case (assocWord[ASEL_LSB +: 2])
                ASEL_START: assocAddr_next = assocStartAddr;
                ASEL_JUMP:  assocAddr_next = assocWord[JUMP_LSB +: ADDR_W];
                ASEL_STM:   assocAddr_next = tableModeAddr;
                default:    assocAddr_next = ASSOC_IDLE;
            endcase
            // a done word wins over any select so the idle loop is always reached
            if (assocWord[ADONE_BIT])
                assocAddr_next = ASSOC_IDLE;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            assocAddr_reg  <= ASSOC_IDLE;
            assocBusy      <= 1'b0;
            assocWord      <= '0;
            assocValid_reg <= 1'b0;
        end else begin
            assocAddr_reg  <= assocAddr_next;
            assocWord      <= assocRom[assocAddr_next];
            assocValid_reg <= running;
            if (loadMode)
                assocBusy <= 1'b0;
            else if (!assocBusy)
                assocBusy <= assocStart;
            else if (assocWord[ADONE_BIT])
                assocBusy <= 1'b0;
        end
    end

    // floating-point word read once per request; divide follows its links
    always_comb begin
        divAddr_next = divAddr_reg;
        if (loadMode)
            divAddr_next = IDLE_ADDR;
        else if (scalValid_reg && scalarWord[DIVREQ_BIT])
            divAddr_next = scalarWord[FPSTART_LSB +: ADDR_W];
        else if (divideBusy)
            divAddr_next = divideWord[LINK_LSB +: ADDR_W];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fpWord       <= '0;
            fpValid      <= 1'b0;
            fpChk_reg    <= 1'b0;
            divAddr_reg  <= IDLE_ADDR;
            divideWord   <= '0;
            divideBusy   <= 1'b0;
            divValid_reg <= 1'b0;
        end else begin
            // no spacing logic here: the issue unit keeps float requests apart
            fpValid   <= running && scalValid_reg && scalarWord[FPREQ_BIT];
            fpChk_reg <= running && scalValid_reg && scalarWord[FPREQ_BIT];
            if (running && scalValid_reg && scalarWord[FPREQ_BIT])
                fpWord <= fpRom[scalarWord[FPSTART_LSB +: ADDR_W]];
            divAddr_reg  <= divAddr_next;
            divideWord   <= divideRom[divAddr_next];
            divideBusy   <= divAddr_next != IDLE_ADDR;
            divValid_reg <= running;
        end
    end

    // odd parity: each group including its parity bit has an odd count
    function automatic logic groupsBad(input logic [SCAL_W-1:0] w, input int dw,
                                       input int ng);
        int gs;
        logic bad;
        bad = 1'b0;
        gs = (dw + ng - 1) / ng;
        for (int g = 0; g < ng; g++) begin
            logic p;
            p = w[dw + g];
            for (int b = 0; b < SCAL_W; b++)
                if (b >= g * gs && b < (g + 1) * gs && b < dw)
                    p ^= w[b];
            if (!p)
                bad = 1'b1;
        end
        return bad;
    endfunction

    // a scalar or float fault is a one-cycle pulse per word, assoc and divide faults stay high while a bad word is reread; the maintenance side must latch it
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            parityFault <= '0;
        else begin
            parityFault.scalar <= scalValid_reg && groupsBad(scalarWord, SCAL_DATA,
                                                             SCAL_PAR);
            parityFault.assoc  <= assocValid_reg && groupsBad({24'h000000, assocWord},
                                                              ASSOC_DATA, ASSOC_PAR);
            parityFault.fp     <= fpChk_reg && groupsBad({72'h0, fpWord}, FP_DATA, FP_PAR);
            parityFault.divide <= divValid_reg && groupsBad({72'h0, divideWord},
                                                            FP_DATA, FP_PAR);
        end
    end

    // checks
    multi_returns_a: assert property (@(posedge clk) disable iff (rst)
        src_reg == SMSEQ_CONT && contDone |=> src_reg == SMSEQ_DISP)
        else $error("continuation did not return to dispatch");
    var_wait_a: assert property (@(posedge clk) disable iff (rst)
        contWait_reg && !endOfOp && !loadMode |=> src_reg == SMSEQ_CONT)
        else $error("variable instruction left before end of operation");
    disp_only_a: assert property (@(posedge clk) disable iff (rst)
        instrTaken |-> src_reg == SMSEQ_DISP && issueReady && instrReady)
        else $error("dispatch without ready instruction and issue");
    sense_addr_a: assert property (@(posedge clk) disable iff (rst)
        src_reg == SMSEQ_CONT && !contWait_reg && !loadMode
        && scalarWord[SEQ_LSB +: 2] == SEQ_SENS
        |=> contAddr_reg[3:0] == $past(senseIndex))
        else $error("sense index not merged into next address");
    assoc_idle_a: assert property (@(posedge clk) disable iff (rst)
        assocBusy && assocWord[ADONE_BIT] && !loadMode |=> !assocBusy && assocAddr_reg == ASSOC_IDLE)
        else $error("associative sequencer did not return to idle");
    fp_once_a: assert property (@(posedge clk) disable iff (rst)
        fpValid |=> !fpValid || $past(scalValid_reg))
        else $error("floating-point word read without request");
    div_start_a: assert property (@(posedge clk) disable iff (rst)
        !loadMode && scalValid_reg && scalarWord[DIVREQ_BIT]
        |=> divAddr_reg == $past(scalarWord[FPSTART_LSB +: ADDR_W]))
        else $error("divide start not taken from start field");
    load_stall_a: assert property (@(posedge clk) disable iff (rst)
        loadMode |-> !instrTaken ##1 src_reg == SMSEQ_DISP)
        else $error("sequencing ran during load");
    // entry checks for dispatch, associative and float, hold checks for continuation, idle check for divide
    disp_word_a: assert property (@(posedge clk) disable iff (rst)
        instrTaken |=> scalValid_reg && !fromContinuation)
        else $error("dispatch word not taken from dispatch store");
    multi_hold_a: assert property (@(posedge clk) disable iff (rst)
        src_reg == SMSEQ_DISP && scalValid_reg && scalarWord[MULTI_BIT] && !loadMode
        |-> !instrTaken ##1 src_reg == SMSEQ_CONT)
        else $error("multicycle entry overtaken by dispatch");
    cont_fetch_a: assert property (@(posedge clk) disable iff (rst)
        src_reg == SMSEQ_CONT && scalarWord[LAST_BIT] && !loadMode |=> !scalValid_reg)
        else $error("continuation fetched past its last word");
    assoc_start_a: assert property (@(posedge clk) disable iff (rst)
        !assocBusy && assocStart && !loadMode
        |=> assocBusy && assocAddr_reg == $past(assocStartAddr))
        else $error("associative start address not taken");
    div_idle_a: assert property (@(posedge clk) disable iff (rst)
        !divideBusy && !(scalValid_reg && scalarWord[DIVREQ_BIT]) && !loadMode
        |=> !divideBusy && divAddr_reg == IDLE_ADDR)
        else $error("divide left its idle loop without a start");
    fp_req_a: assert property (@(posedge clk) disable iff (rst)
        !loadMode && scalValid_reg && scalarWord[FPREQ_BIT]
        |=> fpValid && fpWord == fpRom[$past(scalarWord[FPSTART_LSB +: ADDR_W])])
        else $error("floating-point word not read from start field");
    multi_c: cover property (@(posedge clk) disable iff (rst) src_reg == SMSEQ_CONT ##[1:20] contDone);
    assoc_c: cover property (@(posedge clk) disable iff (rst) assocStart && !assocBusy ##[1:30] !assocBusy);
    div_c:   cover property (@(posedge clk) disable iff (rst) divideBusy ##[1:30] !divideBusy);
    var_c:   cover property (@(posedge clk) disable iff (rst) contWait_reg ##[1:20] !contWait_reg);
endmodule : smseq_sequencer

`default_nettype wire

// ===== tb/smseq_stack_model.sv
// smseq_stack_model: instruction stack, issue unit and maintenance loader.
// assumes the sequencer samples every request on the rising edge of clk.
`timescale 1ns/10ps
`default_nettype none
module smseq_stack_model
    import smseq_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         instrTaken,
    output logic              instrReady,
    output logic [ADDR_W-1:0] funcCode,
    output logic              issueReady,
    output logic              loadMode,
    output smseq_load_s       loadBus
);
    // idle values at time zero
    initial begin
        instrReady = 1'b0;
        funcCode   = 8'h00;
        issueReady = 1'b1;
        loadMode   = 1'b0;
        loadBus    = '0;
    end

    // one channel write; mode low models a stray write outside a load
    task automatic load_word(input logic mode, input logic [2:0] sel, input logic [7:0] a,
                             input logic [SCAL_W-1:0] d);
        @(posedge clk);
        loadMode <= mode;
        loadBus  <= '{1'b1, sel, a, d};
        @(posedge clk);
        loadMode <= 1'b0;
        // released lines carry the inverse, so a stale value cannot pass
        loadBus  <= '{1'b0, ~sel, ~a, ~d};
    endtask : load_word

    // present one code; the issue unit may hold back for some cycles
    task automatic issue(input logic [7:0] code, input int stall);
        @(posedge clk);
        instrReady <= 1'b1;
        funcCode   <= code;
        if (stall != 0) begin
            issueReady <= 1'b0;
            repeat (stall) @(posedge clk);
            issueReady <= 1'b1;
        end
        @(negedge clk);
        for (int i = 0; i < 50 && instrTaken !== 1'b1; i++) @(negedge clk);
        @(posedge clk);
        instrReady <= 1'b0;
        funcCode   <= ~code;
    endtask : issue
endmodule : smseq_stack_model
`default_nettype wire

// ===== tb/testbench.sv
// testbench: loads all stores, then runs dispatch, continuation, float,
// divide, associative and parity scenarios. assumes smseq_pkg compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench
    import smseq_pkg::*;
;
    logic clk = 1'b0;
    logic rst, instrReady, issueReady, loadMode, endOfOp, assocStart;
    logic instrTaken, fromContinuation, assocBusy, fpValid, divideBusy;
    logic [ADDR_W-1:0] funcCode, assocStartAddr, tableModeAddr;
    logic [3:0] senseIndex;
    logic [SCAL_W-1:0] scalarWord;
    logic [ASSOC_W-1:0] assocWord;
    logic [FP_W-1:0] fpWord, divideWord;
    smseq_load_s loadBus;
    smseq_fault_s parityFault;
    int miscompares = 0;
    int cmpCount = 0;
    // target, address, word key for every store location used
    logic [18:0] ldTab [21] = '{{MEM_DISP, 8'h01, 8'hD1}, {MEM_DISP, 8'h02, 8'hD2},
        {MEM_DISP, 8'h03, 8'hD3}, {MEM_DISP, 8'h04, 8'hD4}, {MEM_DISP, 8'h05, 8'hD5},
        {MEM_DISP, 8'h06, 8'hD6}, {MEM_DISP, 8'h07, 8'hD7}, {MEM_DISP, 8'h08, 8'hD8},
        {MEM_CONT, 8'h10, 8'hC0}, {MEM_CONT, 8'h11, 8'hC1}, {MEM_CONT, 8'h20, 8'hC2},
        {MEM_CONT, 8'h35, 8'hC3}, {MEM_CONT, 8'h40, 8'hC4}, {MEM_FP, 8'h80, 8'hF0},
        {MEM_DIV, 8'h90, 8'hE0}, {MEM_DIV, 8'h91, 8'hE1}, {MEM_DIV, 8'h00, 8'hE2},
        {MEM_ASSC, 8'h30, 8'hA0}, {MEM_ASSC, 8'h31, 8'hA1}, {MEM_ASSC, 8'h50, 8'hA2},
        {MEM_ASSC, 8'h00, 8'hA3}};

    always #10 clk = ~clk;

    smseq_sequencer dut_u (.clk(clk), .rst(rst), .loadMode(loadMode), .loadBus(loadBus),
        .instrReady(instrReady), .funcCode(funcCode), .issueReady(issueReady),
        .endOfOp(endOfOp), .senseIndex(senseIndex), .assocStart(assocStart),
        .assocStartAddr(assocStartAddr), .tableModeAddr(tableModeAddr),
        .instrTaken(instrTaken), .fromContinuation(fromContinuation),
        .scalarWord(scalarWord), .assocWord(assocWord), .assocBusy(assocBusy),
        .fpWord(fpWord), .fpValid(fpValid), .divideWord(divideWord),
        .divideBusy(divideBusy), .parityFault(parityFault));

    smseq_stack_model model_u (.clk(clk), .instrTaken(instrTaken), .instrReady(instrReady),
        .funcCode(funcCode), .issueReady(issueReady), .loadMode(loadMode), .loadBus(loadBus));

    // odd parity per 23-bit group, parity bits stacked from bit w up
    function automatic logic [SCAL_W-1:0] par(input logic [SCAL_W-1:0] d, input int n,
                                               input int w);
        logic [SCAL_W-1:0] r;
        r = d;
        for (int g = 0; g < n; g++) r[w+g] = ~^d[g*23 +: 23];
        return r;
    endfunction : par

    function automatic logic [SCAL_W-1:0] sw(input logic [7:0] nx, input logic [1:0] sq,
        input logic [7:0] fs, input logic [4:0] fl, input logic [7:0] tg);
        logic [SCAL_W-1:0] d;
        d = '0;
        d[NEXT_LSB +: 8] = nx;
        d[SEQ_LSB +: 2] = sq;
        d[FPSTART_LSB +: 8] = fs;
        d[FPREQ_BIT +: 5] = fl;
        d[40 +: 8] = tg;
        return par(d, SCAL_PAR, SCAL_DATA);
    endfunction : sw

    // narrow word: low control bits plus a tag to keep words distinct
    function automatic logic [SCAL_W-1:0] nw(input logic [10:0] lo, input logic [7:0] tg,
                                              input int n, input int w);
        return par({82'h0, tg, 19'h0, lo}, n, w);
    endfunction : nw

    function automatic logic [SCAL_W-1:0] word(input logic [7:0] k);
        logic [SCAL_W-1:0] r;
        case (k)
            8'hD3: r = sw(8'h10, SEQ_INC, 8'h00, 5'h08, k);
            8'hD4: r = sw(8'h40, SEQ_INC, 8'h00, 5'h08, k);
            8'hD6: r = sw(8'h00, SEQ_INC, 8'h80, 5'h01, k);
            8'hD7: r = sw(8'h00, SEQ_INC, 8'h90, 5'h02, k);
            8'hC1: r = sw(8'h20, SEQ_JUMP, 8'h00, 5'h00, k);
            8'hC2: r = sw(8'h3C, SEQ_SENS, 8'h00, 5'h00, k);
            8'hC3: r = sw(8'h00, SEQ_INC, 8'h00, 5'h10, k);
            8'hC4: r = sw(8'h00, SEQ_INC, 8'h00, 5'h14, k);
            8'hF0, 8'hE1, 8'hE2: r = nw(11'h000, k, FP_PAR, FP_DATA);
            8'hE0: r = nw(11'h091, k, FP_PAR, FP_DATA);
            8'hA0: r = nw({1'b0, ASEL_JUMP, 8'h31}, k, ASSOC_PAR, ASSOC_DATA);
            8'hA1: r = nw({1'b0, ASEL_STM, 8'h00}, k, ASSOC_PAR, ASSOC_DATA);
            8'hA2: r = nw({1'b1, ASEL_START, 8'h00}, k, ASSOC_PAR, ASSOC_DATA);
            8'hA3: r = nw({1'b0, ASEL_JUMP, 8'h00}, k, ASSOC_PAR, ASSOC_DATA);
            default: r = sw(8'h00, SEQ_INC, 8'h00, 5'h00, k);
        endcase
        // the last dispatch word is stored with one parity bit wrong
        if (k == 8'hD8) r[SCAL_DATA] = ~r[SCAL_DATA];
        return r;
    endfunction : word

    task automatic chk(input string nm, input logic [SCAL_W-1:0] e, input logic [SCAL_W-1:0] g);
        cmpCount++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask : chk

    task automatic step(input logic [7:0] k);
        @(negedge clk);
        chk("scalarWord", word(k), scalarWord);
    endtask : step

    // bounded wait for a status flag of the design to reach a given value
    task automatic await(ref logic s, input logic v);
        @(negedge clk);
        for (int i = 0; i < 6 && s !== v; i++) @(negedge clk);
    endtask : await

    task automatic t_single();
        fork
            model_u.issue(8'h01, 3);
            begin
                @(posedge clk);
                repeat (3) begin
                    @(negedge clk);
                    chk("instrTaken", 1'b0, instrTaken);
                end
            end
        join
        step(8'hD1);
        chk("fromContinuation", 1'b0, fromContinuation);
        @(negedge clk);
        chk("parityFault", 4'h0, parityFault);
        model_u.issue(8'h02, 0);
        step(8'hD2);
        model_u.load_word(1'b0, MEM_DISP, 8'h05, word(8'hD2));
        model_u.issue(8'h05, 0);
        step(8'hD5);
        $display("single-cycle dispatch test done");
    endtask : t_single

    task automatic t_multi();
        model_u.issue(8'h03, 0);
        step(8'hD3);
        step(8'hC0);
        chk("fromContinuation", 1'b1, fromContinuation);
        step(8'hC1);
        step(8'hC2);
        step(8'hC3);
        // the flag follows the held last word for one more cycle
        repeat (2) @(negedge clk);
        chk("fromContinuation", 1'b0, fromContinuation);
        model_u.issue(8'h01, 0);
        step(8'hD1);
        model_u.issue(8'h04, 0);
        step(8'hD4);
        step(8'hC4);
        repeat (4) begin
            @(negedge clk);
            chk("fromContinuation", 1'b1, fromContinuation);
        end
        @(posedge clk);
        endOfOp <= 1'b1;
        await(fromContinuation, 1'b0);
        chk("fromContinuation", 1'b0, fromContinuation);
        @(posedge clk);
        endOfOp <= 1'b0;
        $display("continuation test done");
    endtask : t_multi

    task automatic t_fp_div();
        model_u.issue(8'h06, 0);
        step(8'hD6);
        await(fpValid, 1'b1);
        chk("fpWord", word(8'hF0), fpWord);
        @(negedge clk);
        chk("fpValid", 1'b0, fpValid);
        model_u.issue(8'h07, 0);
        step(8'hD7);
        await(divideBusy, 1'b1);
        chk("divideWord", word(8'hE0), divideWord);
        @(negedge clk);
        chk("divideWord", word(8'hE1), divideWord);
        await(divideBusy, 1'b0);
        chk("divideBusy", 1'b0, divideBusy);
        $display("float and divide test done");
    endtask : t_fp_div

    task automatic t_assoc();
        chk("assocBusy", 1'b0, assocBusy);
        @(posedge clk);
        assocStart <= 1'b1;
        @(posedge clk);
        assocStart <= 1'b0;
        await(assocBusy, 1'b1);
        chk("assocWord", word(8'hA0), assocWord);
        step(8'hD7);
        chk("assocWord", word(8'hA1), assocWord);
        @(negedge clk);
        chk("assocWord", word(8'hA2), assocWord);
        await(assocBusy, 1'b0);
        chk("assocBusy", 1'b0, assocBusy);
        $display("associative test done");
    endtask : t_assoc

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmpCount, miscompares);
        if (miscompares == 0 && cmpCount > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    initial begin
        rst = 1'b1;
        endOfOp = 1'b0;
        senseIndex = 4'h5;
        assocStart = 1'b0;
        assocStartAddr = 8'h30;
        tableModeAddr = 8'h50;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        foreach (ldTab[i]) model_u.load_word(1'b1, ldTab[i][18:16], ldTab[i][15:8],
                                             word(ldTab[i][7:0]));
        t_single();
        t_multi();
        t_fp_div();
        t_assoc();
        model_u.issue(8'h08, 0);
        step(8'hD8);
        @(negedge clk);
        chk("parityFault.scalar", 1'b1, parityFault.scalar);
        $display("parity test done");
        give_verdict();
    end

    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
